// >>> rtl/adpr_regs.vh
`ifndef ADPR_REGS_VH
`define ADPR_REGS_VH

// Serial control word
`define ADPR_WORD_BITS 5'h10
`define ADPR_ADDR_HI 10
`define ADPR_ADDR_LO 9
`define ADPR_ADDR_LEFT 2'h0
`define ADPR_ADDR_RIGHT 2'h1
`define ADPR_ADDR_MODE 2'h2
`define ADPR_ADDR_FORMAT 2'h3

// Level registers
`define ADPR_LEVEL_HI 7
`define ADPR_LEVEL_LO 0
`define ADPR_COMMIT_BIT 8
`define ADPR_LEVEL_RST 8'hff

// Output mode register
`define ADPR_MUTE_BIT 0
`define ADPR_DEEMPH_BIT 1
`define ADPR_FORCE_ZERO_BIT 2
`define ADPR_WLEN_HI 4
`define ADPR_WLEN_LO 3
`define ADPR_ROUTE_HI 8
`define ADPR_ROUTE_LO 5
`define ADPR_MUTE_RST 1'b0
`define ADPR_DEEMPH_RST 1'b0
`define ADPR_FORCE_ZERO_RST 1'b0
`define ADPR_WLEN_RST 2'h0
`define ADPR_ROUTE_RST 4'h9

// Format and clock register
`define ADPR_I2S_BIT 0
`define ADPR_PHASE_BIT 1
`define ADPR_SHARED_BIT 2
`define ADPR_RATIO_BIT 3
`define ADPR_MULT_HI 5
`define ADPR_MULT_LO 4
`define ADPR_GROUP_HI 7
`define ADPR_GROUP_LO 6
`define ADPR_ZDET_BIT 8
`define ADPR_I2S_RST 1'b0
`define ADPR_PHASE_RST 1'b0
`define ADPR_SHARED_RST 1'b0
`define ADPR_RATIO_RST 1'b0
`define ADPR_MULT_RST 2'h0
`define ADPR_GROUP_RST 2'h0
`define ADPR_ZDET_RST 1'b0

// Reserved two-bit field code
`define ADPR_RSVD_CODE 2'h3

// Converter state after reset
`define ADPR_RAMP_RST 8'hff
`define ADPR_BPZ_RST 1'b1

// Timing
`define ADPR_CLK_NS 40
`define ADPR_RATE_GAP_NS 20000
`define ADPR_RATE_GAP_CYC \
  ((`ADPR_RATE_GAP_NS + `ADPR_CLK_NS - 1) / `ADPR_CLK_NS)
`define ADPR_ZERO_RUN_BCLKS 17'h10000

`endif

// >>> rtl/adpr_sync.v
`timescale 1ns/1ps
module adpr_sync
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Asynchronous pin
  input wire pin_i,
  // Filtered level and edges
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);

  reg ff1_q;
  reg ff2_q;
  reg ff3_q;
  reg level_q;
  wire agree;

  assign agree = (ff2_q == ff3_q);
  assign level_o = level_q;
  assign rise_o = agree & ff3_q & ~level_q;
  assign fall_o = agree & ~ff3_q & level_q;

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ff1_q <= 1'b0;
      ff2_q <= 1'b0;
      ff3_q <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      ff1_q <= pin_i;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      if (agree)
      begin
        level_q <= ff3_q;
      end
    end
  end

endmodule

// >>> rtl/adpr_top.v
// Function
// - Four 16-bit program registers, all loaded from one serial data pin.
// - Host shifts 16 bits then strobes latch; word is stored only then.
// - Word bits 10:9 pick register 0 to 3; bits 15:11 are ignored.
// - Bits 7:0 of level registers form the gain code, 00h mutes.
// - Left code written with commit bit 0 is held, applied on commit 1.
// - Right level uses the same held-then-commit scheme with its bit 8.
// - Mode bit 0 mutes both outputs by ramping the gain down gradually.
// - Mode bit 1 enables de-emphasis when high, disables when low.
// - Override low converts; 65536 zero bit clocks force zero if enabled.
// - Mode bit 2 holds output at bipolar zero; writes still accepted.
// - Zero detected with detection on disconnects modulator, else connected.
// - Reset pin low forces bipolar zero and ignores control writes.
// - Mode bits 4:3 give word length 16, 20 or 24; code 11 reserved.
// - Mode bits 5,6 route left and 7,8 route right output.
// - Format bit 0 selects I2S; bit 1 inverts word clock channel phase.
// - Format bit 2 high applies left level code to both channels.
// - Format bit 3 low selects 384fs, high selects 256fs system clock.
// - Format bits 7:6 give rate group; host spaces changes over 20us.
`timescale 1ns/1ps
`include "adpr_regs.vh"
module adpr_top
#(
  parameter [16:0] ZERO_RUN_BCLKS = `ADPR_ZERO_RUN_BCLKS
)
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Three-wire control port
  input wire control_serial_data_i,
  input wire control_shift_clock_i,
  input wire control_latch_strobe_i,
  // Device reset pin
  input wire reset_pin_low_n_i,
  // Audio serial input
  input wire bit_clock_in_i,
  input wire word_clock_in_i,
  input wire audio_data_i,
  // Level control
  output wire [7:0] left_level_code_o,
  output wire [7:0] right_level_code_o,
  output wire [7:0] soft_mute_gain_o,
  // Output mode
  output wire soft_mute_o,
  output wire de_emphasis_enable_o,
  output wire output_force_zero_o,
  output wire [1:0] word_length_select_o,
  output wire [3:0] output_routing_o,
  output wire [1:0] left_route_o,
  output wire [1:0] right_route_o,
  // Format and clocking
  output wire i2s_format_o,
  output wire channel_phase_polarity_o,
  output wire shared_level_control_o,
  output wire clock_ratio_select_o,
  output wire [1:0] rate_multiple_select_o,
  output wire [1:0] rate_group_select_o,
  output wire rate_group_busy_o,
  output wire zero_run_detect_o,
  output wire left_phase_o,
  // Converter output state
  output wire zero_run_active_o,
  output wire bipolar_zero_o,
  output wire modulator_connected_o
);

  localparam integer RATE_GAP_INT = `ADPR_RATE_GAP_CYC;
  localparam [9:0] RATE_GAP_CYC = RATE_GAP_INT[9:0];
  localparam [4:0] WORD_BITS = `ADPR_WORD_BITS;

  // Reserved two-bit codes leave the old setting in place
  function [1:0] keep_valid;
    input [1:0] new_code;
    input [1:0] old_code;
    begin
      if (new_code == `ADPR_RSVD_CODE)
        keep_valid = old_code;
      else
        keep_valid = new_code;
    end
  endfunction

  wire sdat_lvl;
  wire sclk_rise;
  wire latch_rise;
  wire rstpin_lvl;
  wire bclk_rise;
  wire wclk_lvl;
  wire wclk_rise;
  wire wclk_fall;
  wire adat_lvl;

  adpr_sync u_sync_sdat
  (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pin_i(control_serial_data_i),
    .level_o(sdat_lvl), .rise_o(), .fall_o()
  );

  adpr_sync u_sync_sclk
  (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pin_i(control_shift_clock_i),
    .level_o(), .rise_o(sclk_rise), .fall_o()
  );

  adpr_sync u_sync_latch
  (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pin_i(control_latch_strobe_i),
    .level_o(), .rise_o(latch_rise), .fall_o()
  );

  adpr_sync u_sync_rstpin
  (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pin_i(reset_pin_low_n_i),
    .level_o(rstpin_lvl), .rise_o(), .fall_o()
  );

  adpr_sync u_sync_bclk
  (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pin_i(bit_clock_in_i),
    .level_o(), .rise_o(bclk_rise), .fall_o()
  );

  adpr_sync u_sync_wclk
  (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pin_i(word_clock_in_i),
    .level_o(wclk_lvl), .rise_o(wclk_rise), .fall_o(wclk_fall)
  );

  adpr_sync u_sync_adat
  (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pin_i(audio_data_i),
    .level_o(adat_lvl), .rise_o(), .fall_o()
  );

  // Serial shift path
  reg [15:0] shift_q;
  reg [4:0] bitcnt_q;
  wire word_take;
  wire [1:0] waddr;
  wire [15:0] word;

  // Data is resampled through the same depth as the clock, so it lines up
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift_q <= 16'h0000;
      bitcnt_q <= 5'h00;
    end
    else if (!rstpin_lvl)
    begin
      shift_q <= 16'h0000;
      bitcnt_q <= 5'h00;
    end
    else if (latch_rise)
      bitcnt_q <= 5'h00;
    else if (sclk_rise)
    begin
      shift_q <= {shift_q[14:0], sdat_lvl};
      if (bitcnt_q != WORD_BITS)
        bitcnt_q <= bitcnt_q + 5'h01;
    end
  end

  // A short word is dropped rather than stored half-filled
  assign word_take = latch_rise & rstpin_lvl & (bitcnt_q == WORD_BITS);
  assign word = shift_q;
  assign waddr = word[`ADPR_ADDR_HI:`ADPR_ADDR_LO];

  // Register fields
  reg [7:0] left_hold_q;
  reg [7:0] left_live_q;
  reg [7:0] right_hold_q;
  reg [7:0] right_live_q;
  reg mute_q;
  reg deemph_q;
  reg force_zero_q;
  reg [1:0] wlen_q;
  reg [3:0] route_q;
  reg i2s_q;
  reg phase_q;
  reg shared_q;
  reg ratio_q;
  reg [1:0] mult_q;
  reg [1:0] group_q;
  reg zdet_q;

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      left_hold_q <= `ADPR_LEVEL_RST;
      left_live_q <= `ADPR_LEVEL_RST;
      right_hold_q <= `ADPR_LEVEL_RST;
      right_live_q <= `ADPR_LEVEL_RST;
      mute_q <= `ADPR_MUTE_RST;
      deemph_q <= `ADPR_DEEMPH_RST;
      force_zero_q <= `ADPR_FORCE_ZERO_RST;
      wlen_q <= `ADPR_WLEN_RST;
      route_q <= `ADPR_ROUTE_RST;
      i2s_q <= `ADPR_I2S_RST;
      phase_q <= `ADPR_PHASE_RST;
      shared_q <= `ADPR_SHARED_RST;
      ratio_q <= `ADPR_RATIO_RST;
      mult_q <= `ADPR_MULT_RST;
      group_q <= `ADPR_GROUP_RST;
      zdet_q <= `ADPR_ZDET_RST;
    end
    else if (word_take)
    begin
      case (waddr)
        `ADPR_ADDR_LEFT:
        begin
          left_hold_q <= word[`ADPR_LEVEL_HI:`ADPR_LEVEL_LO];
          if (word[`ADPR_COMMIT_BIT])
            left_live_q <= word[`ADPR_LEVEL_HI:`ADPR_LEVEL_LO];
        end
        `ADPR_ADDR_RIGHT:
        begin
          right_hold_q <= word[`ADPR_LEVEL_HI:`ADPR_LEVEL_LO];
          if (word[`ADPR_COMMIT_BIT])
            right_live_q <= word[`ADPR_LEVEL_HI:`ADPR_LEVEL_LO];
        end
        `ADPR_ADDR_MODE:
        begin
          mute_q <= word[`ADPR_MUTE_BIT];
          deemph_q <= word[`ADPR_DEEMPH_BIT];
          force_zero_q <= word[`ADPR_FORCE_ZERO_BIT];
          wlen_q <= keep_valid(word[`ADPR_WLEN_HI:`ADPR_WLEN_LO],
                               wlen_q);
          route_q <= word[`ADPR_ROUTE_HI:`ADPR_ROUTE_LO];
        end
        `ADPR_ADDR_FORMAT:
        begin
          i2s_q <= word[`ADPR_I2S_BIT];
          phase_q <= word[`ADPR_PHASE_BIT];
          shared_q <= word[`ADPR_SHARED_BIT];
          ratio_q <= word[`ADPR_RATIO_BIT];
          mult_q <= keep_valid(word[`ADPR_MULT_HI:`ADPR_MULT_LO],
                               mult_q);
          group_q <= keep_valid(word[`ADPR_GROUP_HI:`ADPR_GROUP_LO],
                                group_q);
          zdet_q <= word[`ADPR_ZDET_BIT];
        end
        default: mute_q <= mute_q;
      endcase
    end
  end

  // Rate group change spacing guard
  reg [9:0] gap_cnt_q;
  wire group_change;

  assign group_change = word_take & (waddr == `ADPR_ADDR_FORMAT) &
    (keep_valid(word[`ADPR_GROUP_HI:`ADPR_GROUP_LO], group_q) != group_q);

  // Only flags the window; the host still owns the spacing
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      gap_cnt_q <= 10'h000;
    else if (group_change)
      gap_cnt_q <= RATE_GAP_CYC;
    else if (gap_cnt_q != 10'h000)
      gap_cnt_q <= gap_cnt_q - 10'h001;
  end

  // Soft mute ramp, one step per word clock period
  reg [7:0] ramp_q;

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ramp_q <= `ADPR_RAMP_RST;
    else if (wclk_rise)
    begin
      if (mute_q && ramp_q != 8'h00)
        ramp_q <= ramp_q - 8'h01;
      else if (!mute_q && ramp_q != 8'hff)
        ramp_q <= ramp_q + 8'h01;
    end
  end

  // Zero-run counter in bit clock periods
  reg [16:0] zrun_q;
  wire zrun_full;

  assign zrun_full = (zrun_q == ZERO_RUN_BCLKS);

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      zrun_q <= 17'h00000;
    else if (bclk_rise)
    begin
      if (adat_lvl)
        zrun_q <= 17'h00000;
      else if (!zrun_full)
        zrun_q <= zrun_q + 17'h00001;
    end
  end

  // Output forcing, registered so the pin-facing state is glitch free
  reg bpz_q;
  reg wclk_seen_q;
  wire bpz_d;

  assign bpz_d = ~rstpin_lvl | force_zero_q |
    (zdet_q & zrun_full);

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bpz_q <= `ADPR_BPZ_RST;
      wclk_seen_q <= 1'b0;
    end
    else
    begin
      bpz_q <= bpz_d;
      if (wclk_rise | wclk_fall)
        wclk_seen_q <= 1'b1;
    end
  end

  // Level codes, shared mode reuses the left code
  assign left_level_code_o = left_live_q;
  assign right_level_code_o = shared_q ? left_live_q : right_live_q;
  assign soft_mute_gain_o = ramp_q;

  assign soft_mute_o = mute_q;
  assign de_emphasis_enable_o = deemph_q;
  assign output_force_zero_o = force_zero_q;
  assign word_length_select_o = wlen_q;
  assign output_routing_o = route_q;
  assign left_route_o = {route_q[0], route_q[1]};
  assign right_route_o = {route_q[2], route_q[3]};

  assign i2s_format_o = i2s_q;
  assign channel_phase_polarity_o = phase_q;
  assign shared_level_control_o = shared_q;
  assign clock_ratio_select_o = ratio_q;
  assign rate_multiple_select_o = mult_q;
  assign rate_group_select_o = group_q;
  assign rate_group_busy_o = (gap_cnt_q != 10'h000);
  assign zero_run_detect_o = zdet_q;
  assign left_phase_o = wclk_seen_q & (wclk_lvl ^ phase_q);

  assign zero_run_active_o = zrun_full;
  assign bipolar_zero_o = bpz_q;
  assign modulator_connected_o = ~bpz_q;

endmodule

// >>> test/adpr_host_model.sv
`timescale 1ns/1ps
module adpr_host_model
(
  // Clock
  input wire ref_clk_i,
  // Three-wire control port
  output logic control_serial_data_o,
  output logic control_shift_clock_o,
  output logic control_latch_strobe_o
);
  initial
  begin
    control_serial_data_o = 1'h0;
    control_shift_clock_o = 1'h0;
    control_latch_strobe_o = 1'h0;
  end

  // Each level stands 4 cycles so the pin synchroniser sees it
  task automatic send(input logic [15:0] w, input int n = 16);
    for (int i = 0; i < n; i++)
    begin
      control_serial_data_o = w[15 - i];
      repeat (4) @(negedge ref_clk_i);
      control_shift_clock_o = 1'h1;
      repeat (4) @(negedge ref_clk_i);
      control_shift_clock_o = 1'h0;
    end
    // Released data line must not keep showing the last bit
    control_serial_data_o = ~control_serial_data_o;
    control_latch_strobe_o = 1'h1;
    repeat (8) @(negedge ref_clk_i);
    control_latch_strobe_o = 1'h0;
    repeat (8) @(negedge ref_clk_i);
  endtask
endmodule

// >>> test/adpr_top_sva.sv
`timescale 1ns/1ps
module adpr_top_sva
#(
  parameter [16:0] ZERO_RUN_BCLKS = 17'h10000
)
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Pins
  input wire control_latch_strobe_i,
  input wire reset_pin_low_n_i,
  // Outputs
  input wire [7:0] left_level_code_o,
  input wire [7:0] right_level_code_o,
  input wire output_force_zero_o,
  input wire [1:0] word_length_select_o,
  input wire [3:0] output_routing_o,
  input wire [1:0] left_route_o,
  input wire [1:0] right_route_o,
  input wire shared_level_control_o,
  input wire [1:0] rate_multiple_select_o,
  input wire [1:0] rate_group_select_o,
  input wire rate_group_busy_o,
  input wire zero_run_detect_o,
  input wire zero_run_active_o,
  input wire bipolar_zero_o,
  input wire modulator_connected_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_pin_held_low;
    !reset_pin_low_n_i [*8];
  endsequence
  // Latch stays high 8 cycles, fields land 3 to 4 after its rise
  sequence s_after_latch;
    $past(control_latch_strobe_i, 3);
  endsequence

  AST_MOD_CONN: assert property (
    modulator_connected_o == !bipolar_zero_o)
    else $error("modulator state disagrees with bipolar zero");
  AST_FORCE_BPZ: assert property (
    output_force_zero_o |=> bipolar_zero_o)
    else $error("override set but output not at bipolar zero");
  AST_PIN_BPZ: assert property (s_pin_held_low |-> bipolar_zero_o)
    else $error("reset pin low but output not at bipolar zero");
  AST_ZERO_BPZ: assert property (zero_run_active_o && zero_run_detect_o
    |=> bipolar_zero_o) else $error("zero run not forced to zero");
  AST_NORMAL: assert property (
    (reset_pin_low_n_i && !output_force_zero_o
    && !(zero_run_active_o && zero_run_detect_o)) [*8] |=> !bipolar_zero_o)
    else $error("output held at zero without cause");
  AST_ROUTE_PAIRS: assert property (
    left_route_o == {output_routing_o[0], output_routing_o[1]} &&
    right_route_o == {output_routing_o[2], output_routing_o[3]})
    else $error("route pair decode wrong");
  AST_RSVD_CODES: assert property (word_length_select_o != 2'h3 &&
    rate_group_select_o != 2'h3 && rate_multiple_select_o != 2'h3)
    else $error("reserved code stored");
  AST_SHARED: assert property (
    (shared_level_control_o && $stable(left_level_code_o)) [*3]
    |-> right_level_code_o == left_level_code_o)
    else $error("shared level not applied to right");
  AST_LATCHED: assert property (
    $changed(output_routing_o) || $changed(left_level_code_o)
    |-> s_after_latch) else $error("field changed without latch");
  AST_GROUP_BUSY: assert property (
    $changed(rate_group_select_o) |=> rate_group_busy_o [*8])
    else $error("group change not flagged busy");
endmodule

bind adpr_top adpr_top_sva #(.ZERO_RUN_BCLKS(ZERO_RUN_BCLKS)) u_sva (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .control_latch_strobe_i(control_latch_strobe_i),
  .reset_pin_low_n_i(reset_pin_low_n_i),
  .left_level_code_o(left_level_code_o),
  .right_level_code_o(right_level_code_o),
  .output_force_zero_o(output_force_zero_o),
  .word_length_select_o(word_length_select_o),
  .output_routing_o(output_routing_o),
  .left_route_o(left_route_o), .right_route_o(right_route_o),
  .shared_level_control_o(shared_level_control_o),
  .rate_multiple_select_o(rate_multiple_select_o),
  .rate_group_select_o(rate_group_select_o),
  .rate_group_busy_o(rate_group_busy_o),
  .zero_run_detect_o(zero_run_detect_o),
  .zero_run_active_o(zero_run_active_o),
  .bipolar_zero_o(bipolar_zero_o),
  .modulator_connected_o(modulator_connected_o)
);

// >>> test/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  logic clk = 0, rst = 1, rpn = 1, bck = 0, wck = 0, ad = 0;
  logic sd, sc, sl, mute, de_emphasis_enable, fz, i2s, phase, shared, ratio, zra, bipolar_zero, modc;
  logic [7:0] lvl_l, lvl_r, gain;
  logic zd, busy, lphase;
  logic [1:0] wlen, grp, lr, rr, mult;
  logic [3:0] route;
  int failures = 0, num_checks = 0, cycles = 0, nb = 0;

  always #20 clk = ~clk;
  // Offset keeps bit clock edges away from the system clock edges
  initial #13 forever #160 bck = ~bck;
  always @(posedge bck)
  begin
    nb++;
    if (nb % 4 == 0) wck = ~wck;
  end

  adpr_host_model u_host (.ref_clk_i(clk), .control_serial_data_o(sd),
    .control_shift_clock_o(sc), .control_latch_strobe_o(sl));
  adpr_top #(.ZERO_RUN_BCLKS(17'h00010)) u_dut (
    .ref_clk_i(clk), .rst_i(rst), .control_serial_data_i(sd),
    .control_shift_clock_i(sc), .control_latch_strobe_i(sl),
    .reset_pin_low_n_i(rpn), .bit_clock_in_i(bck), .word_clock_in_i(wck),
    .audio_data_i(ad), .left_level_code_o(lvl_l), .right_level_code_o(lvl_r),
    .soft_mute_gain_o(gain), .soft_mute_o(mute), .de_emphasis_enable_o(de_emphasis_enable),
    .output_force_zero_o(fz), .word_length_select_o(wlen),
    .output_routing_o(route), .left_route_o(lr), .right_route_o(rr),
    .i2s_format_o(i2s), .channel_phase_polarity_o(phase),
    .shared_level_control_o(shared), .clock_ratio_select_o(ratio),
    .rate_multiple_select_o(mult), .rate_group_select_o(grp),
    .rate_group_busy_o(busy), .zero_run_detect_o(zd),
    .left_phase_o(lphase),
    .zero_run_active_o(zra), .bipolar_zero_o(bipolar_zero),
    .modulator_connected_o(modc));

  task close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      close_out;
    end
  end

  task t_levels;
    u_host.send({5'h1f, 2'h0, 1'h0, 8'h55});
    `CHK(lvl_l, 8'hff)
    u_host.send({5'h00, 2'h0, 1'h1, 8'h55});
    `CHK(lvl_l, 8'h55)
    u_host.send({5'h00, 2'h1, 1'h0, 8'h00});
    `CHK(lvl_r, 8'hff)
    u_host.send({5'h00, 2'h1, 1'h1, 8'h00});
    `CHK(lvl_r, 8'h00)
    u_host.send({5'h1f, 2'h0, 1'h1, 8'h12});
    `CHK(lvl_l, 8'h12)
  endtask

  task t_mode;
    logic [1:0] wl;
    for (int i = 0; i < 16; i++)
    begin
      wl = i % 3;
      u_host.send({5'h00, 2'h2, i[3:0], wl, 1'h0, i[0], i[1]});
      `CHK(route, i[3:0])
      `CHK(wlen, wl)
      `CHK(de_emphasis_enable, i[0])
      `CHK(mute, i[1])
    end
    u_host.send({5'h00, 2'h2, 4'h9, 2'h1, 3'h1});
    `CHK(lr, 2'h2)
    `CHK(rr, 2'h1)
    u_host.send({5'h00, 2'h2, 4'h6, 2'h3, 3'h1});
    `CHK(wlen, 2'h1)
    `CHK(route, 4'h6)
    `CHK(lr, 2'h1)
    `CHK(rr, 2'h2)
    repeat (640) @(negedge clk);
    `CHK(gain < 8'hff && gain > 8'h00, 1'h1)
  endtask

  task t_format;
    for (int i = 0; i < 4; i++)
    begin
      u_host.send({5'h00, 2'h3, 1'h0, i[1:0], i[1:0], i[0], i[1], i[0], i[1]});
      `CHK(grp, i == 3 ? 2'h2 : i[1:0])
      `CHK(ratio, i[0])
      `CHK(i2s, i[1])
      `CHK(phase, i[0])
      `CHK(shared, i[1])
      `CHK(mult, i == 3 ? 2'h2 : i[1:0])
      `CHK(busy, i == 1 || i == 2)
      // Sample well inside the high phase, past the pin synchroniser
      @(posedge wck);
      repeat (8) @(negedge clk);
      `CHK(lphase, ~i[0])
      if (i[1]) `CHK(lvl_r, 8'h12)
      repeat (520) @(negedge clk);
    end
  endtask

  task t_zero;
    u_host.send({5'h00, 2'h3, 9'h100});
    `CHK(bipolar_zero, 1'h1)
    `CHK(modc, 1'h0)
    `CHK(zd, 1'h1)
    ad = 1;
    repeat (40) @(negedge clk);
    `CHK(bipolar_zero, 1'h0)
    ad = 0;
    repeat (200) @(negedge clk);
    `CHK(zra, 1'h1)
    `CHK(bipolar_zero, 1'h1)
    u_host.send({5'h00, 2'h3, 9'h000});
    `CHK(modc, 1'h1)
    `CHK(zd, 1'h0)
  endtask

  task t_force;
    u_host.send({5'h00, 2'h2, 4'h9, 2'h0, 3'h4});
    `CHK(fz, 1'h1)
    `CHK(bipolar_zero, 1'h1)
    u_host.send({5'h00, 2'h0, 1'h1, 8'h33});
    `CHK(lvl_l, 8'h33)
    u_host.send({5'h00, 2'h2, 4'h9, 5'h00});
    `CHK(bipolar_zero, 1'h0)
  endtask

  task t_rpin;
    rpn = 0;
    repeat (10) @(negedge clk);
    `CHK(bipolar_zero, 1'h1)
    u_host.send({5'h00, 2'h0, 1'h1, 8'h44});
    `CHK(lvl_l, 8'h33)
    rpn = 1;
    repeat (12) @(negedge clk);
    `CHK(bipolar_zero, 1'h0)
    u_host.send({5'h00, 2'h0, 1'h1, 8'h66}, 15);
    `CHK(lvl_l, 8'h33)
    u_host.send({5'h00, 2'h0, 1'h1, 8'h77});
    `CHK(lvl_l, 8'h77)
  endtask

  initial
  begin
    repeat (4) @(negedge clk);
    rst = 0;
    @(negedge clk);
    t_levels;
    t_mode;
    t_format;
    t_zero;
    t_force;
    t_rpin;
    close_out;
  end
endmodule
